// ===== core/lrm_regfile.sv
// Purpose: Native register file holding the legacy 32-bit application state
// Assumes: One clock, synchronous reset, word-indexed register port
// Notes:   Float registers modelled as 64-bit significands only
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "lrm_consts.svh"

// Summary of operation
// - One 64-bit instruction pointer shared by both instruction sets.
// - Legacy multimedia and stack-float registers live in float registers 8 to 15.
// - Vector register halves sit in even (low) and odd (high) float registers 16-31.
// - Control flags: bits 31:0 control zero, 63:32 control four; writes need privilege 0.
// - Upper 32 bits of legacy integer registers ignored on legacy entry.
// - On legacy exit upper 32 bits sign-extend bit 31.
// - Shared 32-bit flags; privileged bits writable by privilege and I/O level.
// - One counter is both time stamp counter and interval timer.
// - 64-bit float status holds numeric status, tag word and vector status.
// - 64-bit float control holds numeric control and vector control.
// - Instruction environment holds last opcode, code selector and pointer.
// - Data environment holds last operand selector and offset.
// - Legacy execution keeps status field zero; fields 1-3 may change.
// - Stack config, backing pointers and collection registers stay unchanged.
// - Scratch registers may be left undefined after legacy execution.
// - Previous function state, loop and epilogue counts stay unchanged.
// - Code and stack segment descriptors are 64-bit shared registers.
// - Legacy integers occupy low 32 bits of general registers 8 to 15.
module lrm_regfile (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [63:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [63:0] reg_rdata,
  // Execution context
  input  wire logic [1:0]  current_privilege_level,
  input  wire logic        legacy_enter,
  input  wire logic        legacy_exit,
  // Legacy execution view
  output logic             legacy_active,
  output logic      [63:0] instruction_pointer,
  output logic      [63:0] interval_timer
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [63:0] general_register [0:`LRM_GR_CNT-1];
  logic [63:0] float_register   [0:`LRM_FR_CNT-1];
  logic [63:0] branch_register  [0:7];
  logic [63:0] predicate_register;
  logic [31:0] legacy_flags_reg;
  logic [63:0] legacy_control_flags;
  logic [63:0] fp_status_tag;
  logic [63:0] fp_simd_control;
  logic [63:0] fp_instruction_env;
  logic [63:0] fp_data_env;
  logic [63:0] code_segment_descriptor;
  logic [63:0] stack_segment_descriptor;
  logic [63:0] fpsr;
  logic [63:0] register_stack_config;
  logic [63:0] backing_store_pointer;
  logic [63:0] backing_store_write_ptr;
  logic [63:0] stack_collection_reg;
  logic [63:0] user_collection_reg;
  logic [63:0] compare_value_reg;
  logic [63:0] previous_function_state;
  logic [63:0] loop_count_reg;
  lrm_pkg::lrm_mode_t mode;
  logic [63:0] next_rdata;
  logic [31:0] next_flags;
  logic [1:0]  iopl;
  logic        gr_hit;
  logic        fr_hit;
  logic        br_hit;
  logic [3:0]  gr_idx;
  logic [4:0]  fr_idx;
  logic [2:0]  br_idx;

  // Window decodes for the array regions
  assign gr_hit = (reg_addr >= `LRM_A_GR_BASE) && (reg_addr < `LRM_A_GR_BASE + 8'h10);
  assign fr_hit = (reg_addr >= `LRM_A_FR_BASE) && (reg_addr < `LRM_A_FR_BASE + 8'h20);
  assign br_hit = (reg_addr >= `LRM_A_BR_BASE) && (reg_addr < `LRM_A_BR_BASE + 8'h08);
  assign gr_idx = reg_addr[3:0];
  assign fr_idx = reg_addr[4:0];
  assign br_idx = reg_addr[2:0];
  assign iopl   = legacy_flags_reg[`LRM_IOPL_HI:`LRM_IOPL_LO];

  // Privileged flag bits only move when privilege allows
  always_comb begin
    next_flags = reg_wdata[31:0];
    if (current_privilege_level != 2'h0) begin
      next_flags = (reg_wdata[31:0] & ~`LRM_EFL_PRIV)
                 | (legacy_flags_reg & `LRM_EFL_PRIV);
      if (current_privilege_level <= iopl) begin
        next_flags[9] = reg_wdata[9];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= lrm_pkg::LRM_NATIVE;
    end else if (legacy_enter) begin
      mode <= lrm_pkg::LRM_LEGACY;
    end else if (legacy_exit) begin
      mode <= lrm_pkg::LRM_NATIVE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      legacy_active <= 1'b0;
    end else begin
      legacy_active <= (mode == lrm_pkg::LRM_LEGACY);
    end
  end

  // ----------------------------------------------------------------
  // Shared instruction pointer and timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      instruction_pointer <= `LRM_RST_ZERO;
    end else if (reg_wr && reg_addr == `LRM_A_IP) begin
      instruction_pointer <= reg_wdata;
    end
  end

  // One counter, seen both as time stamp and interval timer
  always_ff @(posedge clk) begin
    if (reset) begin
      interval_timer <= `LRM_RST_ZERO;
    end else if (reg_wr && reg_addr == `LRM_A_TIMER) begin
      interval_timer <= reg_wdata;
    end else begin
      interval_timer <= interval_timer + 64'h1;
    end
  end

  // ----------------------------------------------------------------
  // General registers; legacy integers in 8..15 low halves
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `LRM_GR_CNT; i++) begin
        general_register[i] <= `LRM_RST_ZERO;
      end
    end else if (legacy_exit && mode == lrm_pkg::LRM_LEGACY) begin
      // Upper halves rebuilt at exit; software writes lose to it
      for (int i = `LRM_LEG_GR_LO; i <= `LRM_LEG_GR_HI; i++) begin
        general_register[i][63:32] <= {32{general_register[i][31]}};
      end
    end else if (reg_wr && gr_hit && gr_idx != 4'h0) begin
      if (mode == lrm_pkg::LRM_LEGACY && gr_idx >= 4'h8) begin
        general_register[gr_idx][31:0] <= reg_wdata[31:0];
      end else begin
        general_register[gr_idx] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Float registers 0..31 (+0, +1 constants, legacy and vector views)
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `LRM_FR_CNT; i++) begin
        float_register[i] <= `LRM_RST_ZERO;
      end
    end else if (reg_wr && fr_hit && fr_idx > 5'h1) begin
      // 8..15 multimedia/stack view, 16..31 vector low/high pairs
      float_register[fr_idx] <= reg_wdata;
    end
  end

  // Predicates and branch registers
  always_ff @(posedge clk) begin
    if (reset) begin
      predicate_register <= 64'h0000_0000_0000_0001;
    end else if (reg_wr && reg_addr == `LRM_A_PRED) begin
      predicate_register <= {reg_wdata[63:1], 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        branch_register[i] <= `LRM_RST_ZERO;
      end
    end else if (reg_wr && br_hit) begin
      branch_register[br_idx] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Legacy state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      legacy_flags_reg <= `LRM_EFL_RST;
    end else if (reg_wr && reg_addr == `LRM_A_EFLAGS) begin
      legacy_flags_reg <= next_flags;
    end
  end

  // Writes from any non-zero privilege are dropped silently
  always_ff @(posedge clk) begin
    if (reset) begin
      legacy_control_flags <= `LRM_RST_ZERO;
    end else if (reg_wr && reg_addr == `LRM_A_CFLAGS && current_privilege_level == 2'h0) begin
      legacy_control_flags <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fp_status_tag           <= `LRM_RST_ZERO;
      fp_simd_control         <= `LRM_RST_ZERO;
      fp_instruction_env      <= `LRM_RST_ZERO;
      fp_data_env             <= `LRM_RST_ZERO;
      code_segment_descriptor <= `LRM_RST_ZERO;
      stack_segment_descriptor <= `LRM_RST_ZERO;
    end else if (reg_wr) begin
      if (reg_addr == `LRM_A_FSTAT) begin
        fp_status_tag <= reg_wdata;
      end else if (reg_addr == `LRM_A_FCTRL) begin
        fp_simd_control <= reg_wdata;
      end else if (reg_addr == `LRM_A_FIENV) begin
        fp_instruction_env <= reg_wdata;
      end else if (reg_addr == `LRM_A_FDENV) begin
        fp_data_env <= reg_wdata;
      end else if (reg_addr == `LRM_A_CSD) begin
        code_segment_descriptor <= reg_wdata;
      end else if (reg_addr == `LRM_A_SSD) begin
        stack_segment_descriptor <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Native-guarded state: legacy mode writes fpsr only above status field zero and may not touch the preserved set
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      fpsr <= `LRM_RST_ZERO;
    end else if (reg_wr && reg_addr == `LRM_A_FPSR) begin
      if (mode == lrm_pkg::LRM_LEGACY) begin
        fpsr[63:`LRM_SF0_HI+1] <= reg_wdata[63:`LRM_SF0_HI+1];
      end else begin
        fpsr <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      register_stack_config   <= `LRM_RST_ZERO;
      backing_store_pointer   <= `LRM_RST_ZERO;
      backing_store_write_ptr <= `LRM_RST_ZERO;
      stack_collection_reg    <= `LRM_RST_ZERO;
      user_collection_reg     <= `LRM_RST_ZERO;
      previous_function_state <= `LRM_RST_ZERO;
      loop_count_reg          <= `LRM_RST_ZERO;
    end else if (reg_wr && mode == lrm_pkg::LRM_NATIVE) begin
      // Epilogue count rides inside the saved frame marker
      if (reg_addr == `LRM_A_RSC) begin
        register_stack_config <= reg_wdata;
      end else if (reg_addr == `LRM_A_BSP) begin
        backing_store_pointer <= reg_wdata;
      end else if (reg_addr == `LRM_A_BSPST) begin
        backing_store_write_ptr <= reg_wdata;
      end else if (reg_addr == `LRM_A_RCOLL) begin
        stack_collection_reg <= reg_wdata;
      end else if (reg_addr == `LRM_A_UCOLL) begin
        user_collection_reg <= reg_wdata;
      end else if (reg_addr == `LRM_A_PFS) begin
        previous_function_state <= reg_wdata;
      end else if (reg_addr == `LRM_A_LC) begin
        loop_count_reg <= reg_wdata;
      end
    end
  end

  // Scratch compare value, free for legacy use
  always_ff @(posedge clk) begin
    if (reset) begin
      compare_value_reg <= `LRM_RST_ZERO;
    end else if (reg_wr && reg_addr == `LRM_A_CCV) begin
      compare_value_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = `LRM_RST_ZERO;
    if (gr_hit) begin
      next_rdata = general_register[gr_idx];
    end else if (fr_hit) begin
      if (fr_idx == 5'h0) begin
        next_rdata = `LRM_RST_ZERO;
      end else if (fr_idx == 5'h1) begin
        next_rdata = `LRM_FP_ONE;
      end else begin
        next_rdata = float_register[fr_idx];
      end
    end else if (br_hit) begin
      next_rdata = branch_register[br_idx];
    end else if (reg_addr == `LRM_A_IP) begin
      next_rdata = instruction_pointer;
    end else if (reg_addr == `LRM_A_EFLAGS) begin
      next_rdata = {32'h0000_0000, legacy_flags_reg};
    end else if (reg_addr == `LRM_A_CFLAGS) begin
      next_rdata = legacy_control_flags;
    end else if (reg_addr == `LRM_A_FSTAT) begin
      next_rdata = fp_status_tag;
    end else if (reg_addr == `LRM_A_FCTRL) begin
      next_rdata = fp_simd_control;
    end else if (reg_addr == `LRM_A_FIENV) begin
      next_rdata = fp_instruction_env;
    end else if (reg_addr == `LRM_A_FDENV) begin
      next_rdata = fp_data_env;
    end else if (reg_addr == `LRM_A_CSD) begin
      next_rdata = code_segment_descriptor;
    end else if (reg_addr == `LRM_A_SSD) begin
      next_rdata = stack_segment_descriptor;
    end else if (reg_addr == `LRM_A_TIMER) begin
      next_rdata = interval_timer;
    end else if (reg_addr == `LRM_A_FPSR) begin
      next_rdata = fpsr;
    end else if (reg_addr == `LRM_A_RSC) begin
      next_rdata = register_stack_config;
    end else if (reg_addr == `LRM_A_BSP) begin
      next_rdata = backing_store_pointer;
    end else if (reg_addr == `LRM_A_BSPST) begin
      next_rdata = backing_store_write_ptr;
    end else if (reg_addr == `LRM_A_RCOLL) begin
      next_rdata = stack_collection_reg;
    end else if (reg_addr == `LRM_A_UCOLL) begin
      next_rdata = user_collection_reg;
    end else if (reg_addr == `LRM_A_CCV) begin
      next_rdata = compare_value_reg;
    end else if (reg_addr == `LRM_A_PFS) begin
      next_rdata = previous_function_state;
    end else if (reg_addr == `LRM_A_LC) begin
      next_rdata = loop_count_reg;
    end else if (reg_addr == `LRM_A_MODE) begin
      next_rdata = {63'h0, mode == lrm_pkg::LRM_LEGACY};
    end else if (reg_addr == `LRM_A_PRED) begin
      next_rdata = predicate_register;
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= `LRM_RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `LRM_RST_ZERO;
    end
  end

endmodule

// ===== core/lrm_consts.svh
// Purpose: Offsets, field positions and reset values for the legacy register map
// Assumes: Word-indexed register port, 64-bit data
// Notes:   Offsets are word indices on the plain register port
`ifndef LRM_CONSTS_SVH
`define LRM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LRM_A_IP        8'h00
`define LRM_A_EFLAGS    8'h01
`define LRM_A_CFLAGS    8'h02
`define LRM_A_FSTAT     8'h03
`define LRM_A_FCTRL     8'h04
`define LRM_A_FIENV     8'h05
`define LRM_A_FDENV     8'h06
`define LRM_A_CSD       8'h07
`define LRM_A_SSD       8'h08
`define LRM_A_TIMER     8'h09
`define LRM_A_FPSR      8'h0A
`define LRM_A_RSC       8'h0B
`define LRM_A_BSP       8'h0C
`define LRM_A_BSPST     8'h0D
`define LRM_A_RCOLL     8'h0E
`define LRM_A_UCOLL     8'h0F
`define LRM_A_CCV       8'h10
`define LRM_A_PFS       8'h11
`define LRM_A_LC        8'h12
`define LRM_A_MODE      8'h13
`define LRM_A_PRED      8'h14
`define LRM_A_BR_BASE   8'h18
`define LRM_A_GR_BASE   8'h20
`define LRM_A_FR_BASE   8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LRM_IOPL_LO     12
`define LRM_IOPL_HI     13
`define LRM_SF0_HI      12
`define LRM_LEG_GR_LO   8
`define LRM_LEG_GR_HI   15
`define LRM_FR_LEG_LO   6
`define LRM_FR_CNT      32
`define LRM_GR_CNT      16

// ----------------------------------------------------------------
// Reset and constant values
// ----------------------------------------------------------------
`define LRM_RST_ZERO    64'h0000_0000_0000_0000
`define LRM_FP_ONE      64'h8000_0000_0000_0000
`define LRM_EFL_RST     32'h0000_0002
`define LRM_EFL_PRIV    32'h0027_3200

`endif

// ===== core/lrm_pkg.sv
// Purpose: Types for the legacy register map
// Assumes: Used with lrm_consts.svh
// Notes:   Types only; numbers live in the header
package lrm_pkg;
  typedef enum logic [0:0] {
    LRM_NATIVE,
    LRM_LEGACY
  } lrm_mode_t;
endpackage

// ===== verif/lrm_regfile_chk.sv
// Purpose: Port-level checks of the legacy register file
// Assumes: Sees only the top ports; one clock domain
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/100ps
`include "lrm_consts.svh"

module lrm_regfile_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [63:0] reg_rdata,
  // Execution context
  input wire logic [1:0]  current_privilege_level,
  input wire logic        legacy_enter,
  input wire logic        legacy_exit,
  // Legacy view
  input wire logic        legacy_active,
  input wire logic [63:0] instruction_pointer,
  input wire logic [63:0] interval_timer
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);

  // Pointer write lands one edge later
  AST_IP_WRITE: assert property (
    reg_wr && reg_addr == `LRM_A_IP |=> instruction_pointer == $past(reg_wdata))
    else $error("pointer write not taken");
  AST_IP_READ: assert property (
    reg_rd && reg_addr == `LRM_A_IP |=> reg_rdata == $past(instruction_pointer))
    else $error("pointer read differs from port");
  // Timer steps by one, except at the edge that leaves reset
  AST_TIMER_STEP: assert property (
    !$fell(reset) |-> interval_timer == $past(interval_timer) + 64'h1)
    else $error("timer did not step by one");
  AST_TIMER_READ: assert property (
    reg_rd && reg_addr == `LRM_A_TIMER |=> reg_rdata == $past(interval_timer))
    else $error("timer read differs from timer port");
  AST_TIMER_START: assert property (
    $fell(reset) |-> interval_timer == 64'h0 ##1 interval_timer == 64'h1)
    else $error("timer start after reset wrong");
  // Mode flag trails the entry and exit pulses by two edges
  AST_ENTER: assert property (
    legacy_enter |-> ##2 legacy_active)
    else $error("legacy mode not shown after entry");
  AST_EXIT: assert property (
    legacy_exit && !legacy_enter |-> ##2 !legacy_active)
    else $error("legacy mode still shown after exit");
  AST_FR0: assert property (
    reg_rd && reg_addr == `LRM_A_FR_BASE |=> reg_rdata == 64'h0)
    else $error("float zero not constant");
  AST_FR1: assert property (
    reg_rd && reg_addr == (`LRM_A_FR_BASE + 8'h01) |=> reg_rdata == `LRM_FP_ONE)
    else $error("float one not constant");
  AST_PR0: assert property (
    reg_rd && reg_addr == `LRM_A_PRED |=> reg_rdata[0])
    else $error("predicate zero not true");
  // Read data stands one cycle only, zero elsewhere
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 64'h0)
    else $error("read data outside its cycle");

  // Main scenarios reached
  COV_ENTER: cover property (legacy_enter ##2 legacy_active);
  COV_LEGACY_CONTROL_FLAGS_USER: cover property (reg_wr && reg_addr == `LRM_A_CFLAGS
    && current_privilege_level != 2'h0);
  COV_GR_LEGACY: cover property (legacy_active && reg_wr && reg_addr[7:4] == 4'h2);
endmodule

bind lrm_regfile lrm_regfile_chk u_chk (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .current_privilege_level(current_privilege_level),
  .legacy_enter(legacy_enter), .legacy_exit(legacy_exit),
  .legacy_active(legacy_active), .instruction_pointer(instruction_pointer),
  .interval_timer(interval_timer));

// ===== verif/lrm_exec_model.sv
// Purpose: Execution core facing the register file
// Assumes: Single clock; drives after rising edges
// Notes:   Entry and exit are one-cycle pulses
`timescale 1ns/100ps

module lrm_exec_model (
  // Clock
  input  wire logic       clk,
  // Execution context
  output logic      [1:0] current_privilege_level,
  output logic            legacy_enter,
  output logic            legacy_exit
);
  // Idle: most privileged, native set
  initial begin
    current_privilege_level = 2'h0;
    legacy_enter = 1'b0;
    legacy_exit = 1'b0;
  end

  // Privilege changes between accesses only
  task automatic set_level(input logic [1:0] lvl);
    @(posedge clk);
    current_privilege_level <= lvl;
  endtask

  // One-cycle pulses; both at once lets the entry win in the design
  task automatic pulse(input logic ent, input logic ext);
    @(posedge clk);
    legacy_enter <= ent;
    legacy_exit  <= ext;
    @(posedge clk);
    legacy_enter <= 1'b0;
    legacy_exit  <= 1'b0;
  endtask
endmodule

// ===== verif/tb_top.sv
// Purpose: Self-checking bench of the legacy register file
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Expected values follow the register map only
`timescale 1ns/100ps
`include "lrm_consts.svh"

module tb_top;
  logic        clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [63:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [63:0] reg_rdata;
  logic [1:0]  current_privilege_level;
  logic        legacy_enter;
  logic        legacy_exit;
  logic        legacy_active;
  logic [63:0] instruction_pointer;
  logic [63:0] interval_timer;
  logic [63:0] d;
  int          errors;
  int          checks_done;
  logic [7:0]  tbl [12] = '{8'h88, 8'h8F, 8'h90, 8'h91, 8'h9F, 8'h1F, `LRM_A_CSD,
                            `LRM_A_SSD, `LRM_A_FSTAT, `LRM_A_FCTRL, `LRM_A_FIENV,
                            `LRM_A_FDENV};

  lrm_regfile dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .current_privilege_level(current_privilege_level),
    .legacy_enter(legacy_enter), .legacy_exit(legacy_exit),
    .legacy_active(legacy_active), .instruction_pointer(instruction_pointer),
    .interval_timer(interval_timer));

  lrm_exec_model core (
    .clk(clk), .current_privilege_level(current_privilege_level),
    .legacy_enter(legacy_enter), .legacy_exit(legacy_exit));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [63:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [63:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [63:0] exp);
    logic [63:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask

  task automatic close_out();
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog, far above the 160 or so cycles the run needs
  initial begin
    #50000;
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 64'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rdchk("flags reset", `LRM_A_EFLAGS, 64'h2);
    rdchk("pred reset", `LRM_A_PRED, 64'h1);
    // Privileged flag bits, then the I/O level gate on bit 9
    core.set_level(2'h3);
    wr(`LRM_A_EFLAGS, '1);
    rdchk("flags user", `LRM_A_EFLAGS, 64'h0000_0000_FFD8_CDFF);
    core.set_level(2'h0);
    wr(`LRM_A_EFLAGS, 64'h0000_0000_0000_3200);
    rdchk("flags kernel", `LRM_A_EFLAGS, 64'h0000_0000_0000_3200);
    core.set_level(2'h3);
    wr(`LRM_A_EFLAGS, 64'h0);
    rdchk("flags iopl", `LRM_A_EFLAGS, 64'h0000_0000_0000_3000);
    // Control flags only at privilege zero
    wr(`LRM_A_CFLAGS, 64'hDEAD_BEEF_CAFE_F00D);
    rdchk("legacy_control_flags user", `LRM_A_CFLAGS, 64'h0);
    core.set_level(2'h0);
    wr(`LRM_A_CFLAGS, 64'h1111_2222_3333_4444);
    rdchk("legacy_control_flags kernel", `LRM_A_CFLAGS, 64'h1111_2222_3333_4444);
    core.set_level(2'h1);
    wr(`LRM_A_CFLAGS, 64'h0);
    rdchk("legacy_control_flags level1", `LRM_A_CFLAGS, 64'h1111_2222_3333_4444);
    core.set_level(2'h0);
    wr(`LRM_A_IP, 64'h8765_4321_0FED_CBA8);
    #1 chk("ip port", instruction_pointer, 64'h8765_4321_0FED_CBA8);
    rdchk("ip read", `LRM_A_IP, 64'h8765_4321_0FED_CBA8);
    // All written before any read, so aliased pairs show up
    foreach (tbl[i]) wr(tbl[i], {tbl[i], 8'h5A, 48'h0123_4567_89AB});
    foreach (tbl[i]) rdchk("map", tbl[i], {tbl[i], 8'h5A, 48'h0123_4567_89AB});
    wr(`LRM_A_FR_BASE, '1);
    wr(`LRM_A_FR_BASE + 8'h01, 64'h0);
    wr(`LRM_A_PRED, 64'h0);
    rdchk("fr0", `LRM_A_FR_BASE, 64'h0);
    rdchk("fr1", `LRM_A_FR_BASE + 8'h01, `LRM_FP_ONE);
    rdchk("pr0", `LRM_A_PRED, 64'h1);
    // Legacy round trip
    wr(`LRM_A_GR_BASE + 8'h09, 64'hAAAA_BBBB_0000_0000);
    wr(`LRM_A_GR_BASE + 8'h0A, 64'h0000_0000_8000_0000);
    wr(`LRM_A_BSP, 64'h0BAD_F00D_0000_1000);
    wr(`LRM_A_PFS, 64'h0000_0000_0000_0ABC);
    wr(`LRM_A_FPSR, 64'h0000_0000_0000_1FFF);
    core.pulse(1'b1, 1'b0);
    @(posedge clk);
    #1 chk("active", {63'h0, legacy_active}, 64'h1);
    rdchk("mode on", `LRM_A_MODE, 64'h1);
    wr(`LRM_A_GR_BASE + 8'h09, 64'h1234_5678_7FFF_FFFF);
    wr(`LRM_A_BSP, 64'h0);
    wr(`LRM_A_PFS, 64'h0);
    wr(`LRM_A_FPSR, 64'h0);
    core.pulse(1'b0, 1'b1);
    @(posedge clk);
    #1 chk("inactive", {63'h0, legacy_active}, 64'h0);
    rdchk("gr9", `LRM_A_GR_BASE + 8'h09, 64'h0000_0000_7FFF_FFFF);
    rdchk("gr10", `LRM_A_GR_BASE + 8'h0A, 64'hFFFF_FFFF_8000_0000);
    rdchk("bsp", `LRM_A_BSP, 64'h0BAD_F00D_0000_1000);
    rdchk("pfs", `LRM_A_PFS, 64'h0000_0000_0000_0ABC);
    rd(`LRM_A_FPSR, d);
    chk("sf0", {51'h0, d[12:0]}, 64'h1FFF);
    rd(`LRM_A_TIMER, d);
    chk("timer", interval_timer, d + 64'h1);
    // Entry and exit in one cycle: entry wins
    core.pulse(1'b1, 1'b1);
    rdchk("mode both", `LRM_A_MODE, 64'h1);
    core.pulse(1'b0, 1'b1);
    rdchk("mode off", `LRM_A_MODE, 64'h0);
    wr(8'h40, '1);
    rdchk("unmapped", 8'h40, 64'h0);
    close_out();
  end
endmodule
